// ===== bench/acc_cpu_model.sv
`timescale 1ns/1ps
module acc_cpu_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request side
    input wire logic irq_req_i,
    input wire logic ack_en_i,
    input wire logic [3:0] wait_i,
    // Vector fetch
    output logic vector_taken_o
);
    logic [3:0] cnt_reg;

    // ========================================
    // Acknowledge after a programmable latency, one-cycle pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 4'h0;
            vector_taken_o <= 1'b0;
        end else begin
            vector_taken_o <= 1'b0;
            if (irq_req_i && ack_en_i && !vector_taken_o) begin
                if (cnt_reg == wait_i) begin
                    vector_taken_o <= 1'b1;
                    cnt_reg <= 4'h0;
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end else begin
                cnt_reg <= 4'h0;
            end
        end
    end
endmodule

// ===== bench/analog_comparator_control_tb.sv
`timescale 1ns/1ps
module analog_comparator_control_tb;
    import acc_pkg::*;
    logic core_clk, sys_rst, conv_en, glob_en, taken, ack_en;
    logic req, trig, irq;
    logic [2:0] chan;
    logic [3:0] ack_wait;
    logic [7:0] rdata, d, rb;
    acc_bus_req_t bus;
    acc_analog_t an, a;
    int miscompares, checks_done, cycles;
    logic [1:0] modes [4] = '{MODE_TOGGLE, MODE_RESERVED, MODE_FALL, MODE_RISE};

    acc_top i_acc_top (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .bus_req_i(bus), .rd_data_o(rdata),
        .analog_i(an), .converter_enable_i(conv_en), .channel_field_i(chan), .global_irq_enable_i(glob_en),
        .cmp_vector_taken_i(taken), .cmp_irq_req_o(req), .capture_trig_o(trig), .irq_o(irq));
    acc_cpu_model i_acc_cpu_model (.clk_i(core_clk), .rst_i(sys_rst), .irq_req_i(req), .ack_en_i(ack_en),
        .wait_i(ack_wait), .vector_taken_o(taken));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ========================================
    // Shared tasks
    task automatic test_done();
        if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    task automatic wr_reg(input logic [3:0] ad, input logic [7:0] v);
        @(posedge core_clk);
        bus.wr <= 1'b1;
        bus.addr <= ad;
        bus.wdata <= v;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] ad, output logic [7:0] v);
        @(posedge core_clk);
        bus.rd <= 1'b1;
        bus.addr <= ad;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic set_raw(input logic b);
        @(posedge core_clk);
        an.pos_pin <= b ? 10'h200 : 10'h000;
        an.neg_pin <= 10'h100;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    function automatic logic exp_raw(logic dis, logic bg, logic mux, logic cv, logic [2:0] ch, acc_analog_t x);
        acc_volt_t p, n;
        p = bg ? BANDGAP_LEVEL : x.pos_pin;
        n = (mux && !cv) ? x.converter_inputs[ch] : x.neg_pin;
        return !dis && (p > n);
    endfunction

    function automatic logic exp_flag(logic [1:0] md, logic rise);
        return (md == MODE_TOGGLE) || (rise ? md == MODE_RISE : md == MODE_FALL);
    endfunction

    // Hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        logic dis, bg, mux;
        bus = '0;
        an = '0;
        conv_en = 1'b0;
        chan = 3'h0;
        glob_en = 1'b0;
        ack_en = 1'b1;
        ack_wait = 4'h0;
        sys_rst = 1'b1;
        void'($urandom(32'h4be1));
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Reset values and an unmapped address
        rd_reg(ACC_ADDR_CTRL, d); chk("ctrl_rst", 8'h00, d);
        rd_reg(ACC_ADDR_SFIO, d); chk("sfio_rst", 8'h00, d);
        rd_reg(ACC_ADDR_EVT_STATUS, d); chk("status_rst", 8'h00, d);
        rd_reg(ACC_ADDR_EVT_MASK, d); chk("mask_rst", 8'h00, d);
        wr_reg(4'h9, 8'hff);
        rd_reg(4'h9, d); chk("unmapped", 8'h00, d);
        // Writable bits read back, interrupt enable held at zero; output and flag bits are masked off
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom) & 8'hc7;
            wr_reg(ACC_ADDR_CTRL, d);
            rd_reg(ACC_ADDR_CTRL, rb); chk("ctrl_rw", d, rb & 8'hcf);
            d = 8'($urandom);
            wr_reg(ACC_ADDR_SFIO, d);
            rd_reg(ACC_ADDR_SFIO, rb); chk("sfio_rw", d & 8'h08, rb);
        end
        // Input selection: every channel plus random levels and controls
        for (int i = 0; i < 32; i++) begin
            for (int k = 0; k < 8; k++) a.converter_inputs[k] = acc_volt_t'($urandom);
            a.pos_pin = acc_volt_t'($urandom);
            a.neg_pin = acc_volt_t'($urandom);
            dis = ($urandom % 4) == 0;
            bg = 1'($urandom);
            mux = (i < 8) ? 1'b1 : 1'($urandom);
            @(posedge core_clk);
            an <= a;
            conv_en <= (i < 8) ? 1'b0 : 1'($urandom);
            chan <= 3'(i);
            wr_reg(ACC_ADDR_CTRL, {dis, bg, 6'h00});
            wr_reg(ACC_ADDR_SFIO, {4'h0, mux, 3'h0});
            settle(4);
            rd_reg(ACC_ADDR_CTRL, d);
            chk("cmp_out", {7'h0, exp_raw(dis, bg, mux, conv_en, 3'(i), a)}, {7'h0, d[5]});
        end
        wr_reg(ACC_ADDR_SFIO, 8'h00);
        // Every interrupt mode, both edges
        foreach (modes[m]) begin
            set_raw(1'b0);
            settle(4);
            wr_reg(ACC_ADDR_CTRL, {6'h00, modes[m]});
            wr_reg(ACC_ADDR_CTRL, {3'h0, 1'b1, 2'h0, modes[m]});
            set_raw(1'b1);
            settle(5);
            rd_reg(ACC_ADDR_CTRL, d);
            chk("flag_rise", {7'h0, exp_flag(modes[m], 1'b1)}, {7'h0, d[4]});
            wr_reg(ACC_ADDR_CTRL, {3'h0, 1'b1, 2'h0, modes[m]});
            rd_reg(ACC_ADDR_CTRL, d); chk("flag_w1c", 8'h00, {7'h0, d[4]});
            set_raw(1'b0);
            settle(5);
            rd_reg(ACC_ADDR_CTRL, d);
            chk("flag_fall", {7'h0, exp_flag(modes[m], 1'b0)}, {7'h0, d[4]});
        end
        // Request gating and vector clear, prompt then slow acknowledge
        for (int w = 0; w < 2; w++) begin
            @(posedge core_clk);
            glob_en <= 1'b0;
            ack_wait <= w ? 4'h7 : 4'h0;
            set_raw(1'b0);
            settle(4);
            wr_reg(ACC_ADDR_CTRL, 8'h1b);
            wr_reg(ACC_ADDR_EVT_STATUS, 8'h07);
            set_raw(1'b1);
            settle(6);
            chk("req_gated", 8'h00, {7'h0, req});
            rd_reg(ACC_ADDR_CTRL, d); chk("flag_held", 8'h01, {7'h0, d[4]});
            @(posedge core_clk);
            glob_en <= 1'b1;
            settle(1);
            chk("req_on", 8'h01, {7'h0, req});
            settle(14);
            chk("req_off", 8'h00, {7'h0, req});
            rd_reg(ACC_ADDR_CTRL, d); chk("flag_vec", 8'h00, {7'h0, d[4]});
        end
        // Event status, mask and level interrupt
        rd_reg(ACC_ADDR_EVT_STATUS, d); chk("status", 8'h03, d);
        wr_reg(ACC_ADDR_EVT_MASK, 8'h02); settle(2); chk("irq_mask", 8'h01, {7'h0, irq});
        wr_reg(ACC_ADDR_EVT_STATUS, 8'h02); settle(2); chk("irq_clr", 8'h00, {7'h0, irq});
        wr_reg(ACC_ADDR_EVT_MASK, 8'h01); settle(2); chk("irq_mode", 8'h01, {7'h0, irq});
        wr_reg(ACC_ADDR_EVT_MASK, 8'h00); settle(2); chk("irq_off", 8'h00, {7'h0, irq});
        rd_reg(ACC_ADDR_EVT_STATUS, d); chk("status_w1c", 8'h01, d);
        // Capture routing and synchroniser latency
        wr_reg(ACC_ADDR_CTRL, 8'h04);
        set_raw(1'b0);
        settle(5);
        set_raw(1'b1);
        settle(1); chk("trig_early", 8'h00, {7'h0, trig});
        settle(2); chk("trig_on", 8'h01, {7'h0, trig});
        wr_reg(ACC_ADDR_CTRL, 8'h00);
        settle(2); chk("trig_off", 8'h00, {7'h0, trig});
        test_done();
    end
endmodule

// ===== hw/acc_front_end.sv
`timescale 1ns/1ps
module acc_front_end
    import acc_pkg::*;
(
    // Selection
    input wire acc_fe_ctrl_t ctrl_i,
    // Analog levels
    input wire acc_analog_t analog_i,
    // Unsynchronised decision
    output logic raw_o
);

    acc_volt_t pos_level;
    acc_volt_t neg_level;

    always_comb begin
        pos_level = ctrl_i.cmp_bandgap_select ? BANDGAP_LEVEL : analog_i.pos_pin; // R7
        if (ctrl_i.cmp_mux_enable && !ctrl_i.converter_enable) begin
            neg_level = analog_i.converter_inputs[ctrl_i.channel_field]; // R2
        end else begin
            neg_level = analog_i.neg_pin; // R3
        end
        // Powered-off comparator decides low
        raw_o = !ctrl_i.cmp_disable && (pos_level > neg_level); // R1
    end

endmodule

// ===== hw/acc_pkg.sv
// Contract
// R1 - Raw result high when positive exceeds negative
// R2 - Mux on, converter off: channel drives negative
// R3 - Mux off or converter on: negative pin
// R4 - Mux enable is writable bit 3
// R5 - Disable bit 7 powers comparator off
// R6 - Software drops interrupt enable before disable change
// R7 - Bandgap bit 6 replaces positive pin
// R8 - Output bit 5 synchronised, 1-2 cycles
// R9 - Flag bit 4 set on selected event
// R10 - Flag clears on vector or written one
// R11 - Request needs flag, enable bit 3, global
// R12 - Capture bit 2 routes output to timer
// R13 - Mode 00 toggle, 10 fall, 11 rise
// R14 - Software drops interrupt enable before mode change
// R15 - Converter enable comes from converter register
// R16 - Writable bits reset to zero
// R17 - Reserved mode 01 never sets flag
package acc_pkg;

    // ========================================
    // Register port
    localparam int ACC_ADDR_W = 4;
    localparam logic [ACC_ADDR_W-1:0] ACC_ADDR_CTRL = 4'h0;
    localparam logic [ACC_ADDR_W-1:0] ACC_ADDR_SFIO = 4'h1;
    localparam logic [ACC_ADDR_W-1:0] ACC_ADDR_EVT_STATUS = 4'h2;
    localparam logic [ACC_ADDR_W-1:0] ACC_ADDR_EVT_MASK = 4'h3;

    // ========================================
    // Field positions
    localparam int CTRL_DISABLE_BIT = 7;
    localparam int CTRL_BANDGAP_BIT = 6;
    localparam int CTRL_OUTPUT_BIT = 5;
    localparam int CTRL_FLAG_BIT = 4;
    localparam int CTRL_IRQ_EN_BIT = 3;
    localparam int CTRL_CAPTURE_BIT = 2;
    localparam int CTRL_MODE_HI_BIT = 1;
    localparam int CTRL_MODE_LO_BIT = 0;
    localparam int SFIO_MUX_EN_BIT = 3;
    localparam int EVT_MODE_BIT = 0;
    localparam int EVT_RISE_BIT = 1;
    localparam int EVT_FALL_BIT = 2;
    localparam int EVT_W = 3;

    // ========================================
    // Reset values
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [EVT_W-1:0] EVT_STATUS_RST = 3'h0;
    localparam logic [EVT_W-1:0] EVT_MASK_RST = 3'h0;

    // ========================================
    // Interrupt mode codes
    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_RISE = 2'h3;

    // ========================================
    // Timing
    localparam int SYNC_STAGES = 2;

    // ========================================
    // Analog levels, coded as unsigned numbers
    localparam int VOLT_W = 10;
    typedef logic [VOLT_W-1:0] acc_volt_t;
    // Arbitrary bandgap level for the model
    localparam acc_volt_t BANDGAP_LEVEL = 10'h100;

    typedef struct packed {
        acc_volt_t pos_pin;
        acc_volt_t neg_pin;
        logic [7:0][VOLT_W-1:0] converter_inputs;
    } acc_analog_t;

    typedef struct packed {
        logic cmp_disable;
        logic cmp_bandgap_select;
        logic cmp_mux_enable;
        logic converter_enable;
        logic [2:0] channel_field;
    } acc_fe_ctrl_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ACC_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } acc_bus_req_t;

endpackage

// ===== hw/acc_sync.sv
`timescale 1ns/1ps
module acc_sync
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Level in and out
    input wire logic d_i,
    output logic q_o
);

    logic meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule

// ===== hw/acc_top.sv
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire acc_bus_req_t bus_req_i,
    output logic [7:0] rd_data_o,
    // Analog side
    input wire acc_analog_t analog_i,
    // Converter state
    input wire logic converter_enable_i,
    input wire logic [2:0] channel_field_i,
    // CPU interrupt handshake
    input wire logic global_irq_enable_i,
    input wire logic cmp_vector_taken_i,
    // Outputs
    output logic cmp_irq_req_o,
    output logic capture_trig_o,
    output logic irq_o
);

    // ========================================
    // Helpers

    function automatic logic mode_hit(input logic [1:0] mode, input logic cur, input logic prev);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            MODE_TOGGLE: hit = cur ^ prev;
            MODE_RESERVED: hit = 1'b0;
            MODE_FALL: hit = prev & ~cur;
            MODE_RISE: hit = cur & ~prev;
        endcase
        return hit;
    endfunction

    // Set beats clear in the same cycle
    function automatic logic [EVT_W-1:0] set_clr(input logic [EVT_W-1:0] cur,
                                                  input logic [EVT_W-1:0] set,
                                                  input logic [EVT_W-1:0] clr);
        return (cur & ~clr) | set;
    endfunction

    // ========================================
    // Register state

    logic cmp_disable_reg;
    logic cmp_bandgap_select_reg;
    logic cmp_irq_flag_reg;
    logic cmp_irq_flag_next;
    logic cmp_irq_enable_reg;
    logic cmp_capture_enable_reg;
    logic [1:0] cmp_irq_mode_reg;
    logic cmp_mux_enable_reg;
    logic [EVT_W-1:0] evt_status_reg;
    logic [EVT_W-1:0] evt_status_next;
    logic [EVT_W-1:0] evt_mask_reg;
    logic prev_out_reg;
    logic [1:0] settle_reg;

    logic raw_cmp;
    logic cmp_sync_output;
    acc_fe_ctrl_t fe_ctrl;

    logic wr_ctrl;
    logic wr_sfio;
    logic wr_status;
    logic wr_mask;
    logic settled;
    logic rise_evt;
    logic fall_evt;
    logic mode_evt;
    logic flag_clr;

    // ========================================
    // Analog path

    assign fe_ctrl.cmp_disable = cmp_disable_reg; // R5
    assign fe_ctrl.cmp_bandgap_select = cmp_bandgap_select_reg; // R7
    assign fe_ctrl.cmp_mux_enable = cmp_mux_enable_reg;
    assign fe_ctrl.converter_enable = converter_enable_i; // R15
    assign fe_ctrl.channel_field = channel_field_i;

    acc_front_end u_front_end (
        .ctrl_i(fe_ctrl),
        .analog_i(analog_i),
        .raw_o(raw_cmp)
    );

    acc_sync u_sync (
        .clk_i(core_clk_i),
        .rst_i(sys_rst_i),
        .d_i(raw_cmp),
        .q_o(cmp_sync_output) // R8
    );

    // ========================================
    // Address decode

    assign wr_ctrl = bus_req_i.wr && (bus_req_i.addr == ACC_ADDR_CTRL);
    assign wr_sfio = bus_req_i.wr && (bus_req_i.addr == ACC_ADDR_SFIO);
    assign wr_status = bus_req_i.wr && (bus_req_i.addr == ACC_ADDR_EVT_STATUS);
    assign wr_mask = bus_req_i.wr && (bus_req_i.addr == ACC_ADDR_EVT_MASK);

    // ========================================
    // Control bits

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_disable_reg <= 1'b0; // R16
            cmp_bandgap_select_reg <= 1'b0;
            cmp_irq_enable_reg <= 1'b0;
            cmp_capture_enable_reg <= 1'b0;
            cmp_irq_mode_reg <= MODE_RST;
        end else if (wr_ctrl) begin
            cmp_disable_reg <= bus_req_i.wdata[CTRL_DISABLE_BIT]; // R5
            cmp_bandgap_select_reg <= bus_req_i.wdata[CTRL_BANDGAP_BIT]; // R7
            cmp_irq_enable_reg <= bus_req_i.wdata[CTRL_IRQ_EN_BIT];
            cmp_capture_enable_reg <= bus_req_i.wdata[CTRL_CAPTURE_BIT]; // R12
            cmp_irq_mode_reg <= {bus_req_i.wdata[CTRL_MODE_HI_BIT], bus_req_i.wdata[CTRL_MODE_LO_BIT]}; // R13
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_mux_enable_reg <= 1'b0;
        end else if (wr_sfio) begin
            cmp_mux_enable_reg <= bus_req_i.wdata[SFIO_MUX_EN_BIT]; // R4
        end
    end

    // ========================================
    // Event detection
    // Synchroniser output starts low, so edges are ignored until it has filled;
    // prev_out_reg still holds that low then, so a comparator high at reset raises a rise.

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            settle_reg <= 2'h0;
            prev_out_reg <= 1'b0;
        end else begin
            if (!settled) begin
                settle_reg <= settle_reg + 2'h1;
            end
            prev_out_reg <= cmp_sync_output;
        end
    end

    assign settled = (settle_reg == 2'(SYNC_STAGES));
    assign rise_evt = settled && cmp_sync_output && !prev_out_reg;
    assign fall_evt = settled && !cmp_sync_output && prev_out_reg;
    assign mode_evt = settled && mode_hit(cmp_irq_mode_reg, cmp_sync_output, prev_out_reg); // R13 R17

    // ========================================
    // Comparator flag

    assign flag_clr = cmp_vector_taken_i || (wr_ctrl && bus_req_i.wdata[CTRL_FLAG_BIT]); // R10
    assign cmp_irq_flag_next = mode_evt || (cmp_irq_flag_reg && !flag_clr); // R9

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_irq_flag_reg <= 1'b0;
        end else begin
            cmp_irq_flag_reg <= cmp_irq_flag_next; // R9 R10
        end
    end

    // ========================================
    // Event status and mask

    assign evt_status_next = set_clr(evt_status_reg,
                                     {fall_evt, rise_evt, mode_evt},
                                     wr_status ? bus_req_i.wdata[EVT_W-1:0] : EVT_STATUS_RST);

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            evt_status_reg <= EVT_STATUS_RST;
        end else begin
            evt_status_reg <= evt_status_next;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            evt_mask_reg <= EVT_MASK_RST;
        end else if (wr_mask) begin
            evt_mask_reg <= bus_req_i.wdata[EVT_W-1:0];
        end
    end

    // ========================================
    // Outputs
    // Each output is registered, so it trails its cause by one cycle.

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_irq_req_o <= 1'b0;
            capture_trig_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            cmp_irq_req_o <= cmp_irq_flag_reg && cmp_irq_enable_reg && global_irq_enable_i; // R11
            capture_trig_o <= cmp_capture_enable_reg && cmp_sync_output; // R12
            irq_o <= |(evt_status_reg & evt_mask_reg);
        end
    end

    // ========================================
    // Read port
    // Only this block's bit of the shared register is held here; the rest read zero.

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 8'h00;
        end else if (bus_req_i.rd) begin
            unique case (bus_req_i.addr)
                ACC_ADDR_CTRL: rd_data_o <= {cmp_disable_reg, cmp_bandgap_select_reg,
                                             cmp_sync_output, cmp_irq_flag_reg,
                                             cmp_irq_enable_reg, cmp_capture_enable_reg,
                                             cmp_irq_mode_reg}; // R8
                ACC_ADDR_SFIO: rd_data_o <= 8'(cmp_mux_enable_reg) << SFIO_MUX_EN_BIT;
                ACC_ADDR_EVT_STATUS: rd_data_o <= 8'(evt_status_reg);
                ACC_ADDR_EVT_MASK: rd_data_o <= 8'(evt_mask_reg);
                default: rd_data_o <= 8'h00;
            endcase
        end else begin
            rd_data_o <= 8'h00;
        end
    end

    // ========================================
    // Checks

    sync_latency_a: assert property ( // R8
        @(posedge core_clk_i) disable iff (sys_rst_i)
        settled && $past(settled, 2) |-> cmp_sync_output == $past(raw_cmp, 2)
    ) else $error("synchronised output does not follow raw result by two cycles");

    disable_off_a: assert property ( // R5
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_ctrl && bus_req_i.wdata[CTRL_DISABLE_BIT] |=> cmp_disable_reg ##1 !raw_cmp [*2]
            or !cmp_disable_reg
    ) else $error("disabled comparator did not go low");

    mux_enable_a: assert property ( // R4
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_sfio |=> cmp_mux_enable_reg == $past(bus_req_i.wdata[SFIO_MUX_EN_BIT])
    ) else $error("mux enable bit not written");

    flag_set_a: assert property ( // R9
        @(posedge core_clk_i) disable iff (sys_rst_i)
        settled && mode_hit(cmp_irq_mode_reg, cmp_sync_output, prev_out_reg) |=> cmp_irq_flag_reg
    ) else $error("flag not set on selected event");

    flag_clear_a: assert property ( // R10
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cmp_vector_taken_i && !mode_evt |=> !cmp_irq_flag_reg
    ) else $error("flag not cleared when vector taken");

    flag_hold_a: assert property ( // R10
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cmp_irq_flag_reg && !cmp_vector_taken_i && !wr_ctrl |=> cmp_irq_flag_reg
    ) else $error("flag dropped without a clear");

    irq_request_a: assert property ( // R11
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cmp_irq_req_o |-> $past(cmp_irq_flag_reg) && $past(cmp_irq_enable_reg) && $past(global_irq_enable_i)
    ) else $error("interrupt request without flag and enables");

    capture_route_a: assert property ( // R12
        @(posedge core_clk_i) disable iff (sys_rst_i)
        ##1 capture_trig_o == ($past(cmp_capture_enable_reg) && $past(cmp_sync_output))
    ) else $error("capture trigger does not follow output under enable");

    fall_mode_a: assert property ( // R13
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cmp_irq_mode_reg == MODE_FALL && rise_evt && !cmp_irq_flag_reg && !wr_ctrl |=> !cmp_irq_flag_reg
    ) else $error("falling mode set flag on a rise");

    reserved_mode_a: assert property ( // R17
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cmp_irq_mode_reg == MODE_RESERVED && !cmp_irq_flag_reg && !wr_ctrl |=> !cmp_irq_flag_reg
    ) else $error("reserved mode set the flag");

    reset_values_a: assert property ( // R16
        @(posedge core_clk_i)
        $past(sys_rst_i) && !sys_rst_i |-> !cmp_disable_reg && !cmp_bandgap_select_reg
            && !cmp_irq_flag_reg && !cmp_irq_enable_reg && !cmp_capture_enable_reg
            && cmp_irq_mode_reg == MODE_RST && !cmp_mux_enable_reg
    ) else $error("writable bits not zero after reset");

    read_idle_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !bus_req_i.rd |=> rd_data_o == 8'h00
    ) else $error("read data not zero outside a read");

    ctrl_read_a: assert property ( // R8
        @(posedge core_clk_i) disable iff (sys_rst_i)
        bus_req_i.rd && bus_req_i.addr == ACC_ADDR_CTRL |=> rd_data_o[CTRL_OUTPUT_BIT] == $past(cmp_sync_output)
    ) else $error("output bit read does not show synchronised output");

    sfio_read_a: assert property ( // R4
        @(posedge core_clk_i) disable iff (sys_rst_i)
        bus_req_i.rd && bus_req_i.addr == ACC_ADDR_SFIO |=> rd_data_o[SFIO_MUX_EN_BIT] == $past(cmp_mux_enable_reg)
    ) else $error("mux enable read back wrong");

    chan_select_a: assert property ( // R2
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cmp_mux_enable_reg && !converter_enable_i && !cmp_disable_reg && !cmp_bandgap_select_reg
            |-> raw_cmp == (analog_i.pos_pin > analog_i.converter_inputs[channel_field_i])
    ) else $error("selected channel not used as negative input");

    neg_pin_a: assert property ( // R3
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (!cmp_mux_enable_reg || converter_enable_i) && !cmp_disable_reg && !cmp_bandgap_select_reg
            |-> raw_cmp == (analog_i.pos_pin > analog_i.neg_pin)
    ) else $error("negative pin not used as negative input");

    bandgap_pos_a: assert property ( // R7
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cmp_bandgap_select_reg && !cmp_disable_reg && (!cmp_mux_enable_reg || converter_enable_i)
            |-> raw_cmp == (BANDGAP_LEVEL > analog_i.neg_pin)
    ) else $error("bandgap level not used as positive input");

    mode_write_a: assert property ( // R13
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_ctrl |=> cmp_irq_mode_reg == $past(bus_req_i.wdata[CTRL_MODE_HI_BIT:CTRL_MODE_LO_BIT])
    ) else $error("interrupt mode not written");

    capture_write_a: assert property ( // R12
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_ctrl |=> cmp_capture_enable_reg == $past(bus_req_i.wdata[CTRL_CAPTURE_BIT])
    ) else $error("capture enable not written");

    flag_w1c_a: assert property ( // R10
        @(posedge core_clk_i) disable iff (sys_rst_i)
        wr_ctrl && bus_req_i.wdata[CTRL_FLAG_BIT] && !mode_evt |=> !cmp_irq_flag_reg
    ) else $error("flag not cleared by written one");

    rise_status_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        rise_evt |=> evt_status_reg[EVT_RISE_BIT]
    ) else $error("rise event not recorded");

    fall_status_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        fall_evt |=> evt_status_reg[EVT_FALL_BIT]
    ) else $error("fall event not recorded");

    irq_level_a: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        ##1 irq_o == |($past(evt_status_reg) & $past(evt_mask_reg))
    ) else $error("interrupt level does not follow masked status");

endmodule
